/* File: pmrb_bank.v */
/*
  PHY management register bank for two copper ports, reached by a
  management controller over MDC/MDIO and by the switch host port.
  Assumes mdc_in and mdio_in come from pins (synchronised here), and that
  host and status inputs are on mclk_in. MDC must be slower than mclk/4.
*/
`timescale 1ns/10ps
`include "pmrb_consts.vh"

module pmrb_bank #(
  parameter [15:0] ID_HIGH = 16'hA5A5, // Arbitrary identifier value
  parameter [15:0] ID_LOW  = 16'h5A5A  // Arbitrary identifier value
) (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire        mdc_in,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe_n_out,
  input  wire        gc13_wr_in,
  input  wire [7:0]  gc13_data_in,
  input  wire        host_wr_in,
  input  wire        host_rd_in,
  input  wire        host_port_in,
  input  wire [4:0]  phy_register_index_in,
  input  wire [15:0] host_wdata_in,
  output reg  [15:0] host_rdata_out,
  input  wire [1:0]  an_done_in,
  input  wire [1:0]  link_up_in,
  input  wire [1:0]  far_end_fault_in,
  input  wire [4:0]  lp_ability_p1_in,
  input  wire [4:0]  lp_ability_p2_in,
  input  wire [1:0]  polarity_rev_in,
  input  wire        cable_diag_done_in,
  input  wire [1:0]  cable_diag_result_in,
  input  wire        cable_diag_short_in,
  input  wire [8:0]  cable_diag_count_in,
  output wire [1:0]  far_loopback_out,
  output wire [1:0]  force_100_out,
  output wire [1:0]  an_enable_out,
  output wire [1:0]  power_down_out,
  output reg  [1:0]  restart_an_out,
  output wire [1:0]  full_duplex_out,
  output wire [1:0]  crossover_algorithm_select_out,
  output wire [1:0]  force_mdi_out,
  output wire [1:0]  disable_mdix_out,
  output wire        disable_far_fault_out,
  output wire [1:0]  disable_tx_out,
  output wire [1:0]  disable_led_out,
  output wire [4:0]  adv_ability_p1_out,
  output wire [4:0]  adv_ability_p2_out,
  output wire        cable_diag_start_out
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SOF  = 5'h02;
  localparam [4:0] ST_HDR  = 5'h04;
  localparam [4:0] ST_TA   = 5'h08;
  localparam [4:0] ST_DATA = 5'h10;

  reg  [15:0] ctl_p1;
  reg  [15:0] ctl_p2;
  reg  [15:0] adv_p1;
  reg  [15:0] adv_p2;
  reg         cdg_run;
  reg  [4:0]  base_addr;
  reg         addr_prog;
  reg         mdc_s1;
  reg         mdc_s2;
  reg         mdc_prev;
  reg         mdio_s1;
  reg         mdio_s2;
  reg  [4:0]  state;
  reg  [5:0]  pre_cnt;
  reg  [3:0]  bit_cnt;
  reg  [11:0] hdr;
  reg  [15:0] shreg;
  reg         hit;
  reg         hit_port;
  reg         mw_pend;
  reg         mw_port;
  reg  [4:0]  mw_idx;
  reg  [15:0] mw_data;
  wire        mdc_rise;
  wire [4:0]  addr_p1;
  wire [4:0]  addr_p2;
  wire        wr_en;
  wire        wr_port;
  wire [4:0]  wr_idx;
  wire [15:0] wr_data;

  // Readback of one register; port is 0 for port one, 1 for port two
  function [15:0] rd_word;
    input       port;
    input [4:0] idx;
    begin
      case (idx)
        `PMRB_IDX_CTL:
          rd_word = port ? (ctl_p2 & `PMRB_CTL_MASK_P2) : (ctl_p1 & `PMRB_CTL_MASK_P1);
        `PMRB_IDX_STS:
          rd_word = `PMRB_STS_ABIL
                  | ({15'h0000, an_done_in[port]} << `PMRB_STS_ANDONE)
                  | ({15'h0000, far_end_fault_in[port]} << `PMRB_STS_FEF)
                  | ({15'h0000, (port ? ctl_p2[`PMRB_CTL_ANEN]
                                      : ctl_p1[`PMRB_CTL_ANEN])} << `PMRB_STS_ANCAP)
                  | ({15'h0000, link_up_in[port]} << `PMRB_STS_LINK);
        `PMRB_IDX_IDH:
          rd_word = ID_HIGH;
        `PMRB_IDX_IDL:
          rd_word = ID_LOW;
        `PMRB_IDX_ADV:
          rd_word = (port ? adv_p2 : adv_p1) | `PMRB_ADV_SEL;
        // Pause sits above a reserved bit, so it is placed apart from the speed bits
        `PMRB_IDX_LPA:
          rd_word = ({15'h0000, (port ? lp_ability_p2_in[4] : lp_ability_p1_in[4])} << `PMRB_ABL_PAUSE)
                  | ({12'h000, (port ? lp_ability_p2_in[3:0] : lp_ability_p1_in[3:0])} << `PMRB_ABL_LO);
        `PMRB_IDX_CDG:
          rd_word = port ? {cdg_run, cable_diag_result_in, cable_diag_short_in,
                            3'h0, cable_diag_count_in} : 16'h0000;
        `PMRB_IDX_SPC:
          rd_word = {15'h0000, polarity_rev_in[port]} << `PMRB_SPC_POL;
        default:
          rd_word = 16'h0000;
      endcase
    end
  endfunction

  assign addr_p1 = addr_prog ? base_addr : `PMRB_ADDR_P1;
  assign addr_p2 = addr_prog ? (base_addr + 5'h01) : `PMRB_ADDR_P2;

  // Host writes take the bank this cycle; a colliding frame write waits for the first cycle with no host write
  assign wr_en   = host_wr_in | mw_pend;
  assign wr_port = host_wr_in ? host_port_in : mw_port;
  assign wr_idx  = host_wr_in ? phy_register_index_in : mw_idx;
  assign wr_data = host_wr_in ? host_wdata_in : mw_data;

  assign mdc_rise = mdc_s2 & ~mdc_prev;

  // Programmed base address
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      base_addr <= `PMRB_ADDR_P1;
      addr_prog <= 1'b0;
    end
    else if (gc13_wr_in)
    begin
      base_addr <= gc13_data_in[`PMRB_GC_ADDR_HI:`PMRB_GC_ADDR_LO];
      addr_prog <= 1'b1;
    end
  end

  // Register storage, shared by both access paths
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ctl_p1         <= `PMRB_CTL_RESET;
      ctl_p2         <= `PMRB_CTL_RESET;
      adv_p1         <= `PMRB_ADV_RESET;
      adv_p2         <= `PMRB_ADV_RESET;
      cdg_run        <= 1'b0;
      restart_an_out <= 2'b00;
    end
    else
    begin
      restart_an_out <= 2'b00;
      // Done clears the run flag unless a new start lands the same cycle
      if (cable_diag_done_in)
        cdg_run <= 1'b0;
      if (wr_en)
      begin
        case (wr_idx)
          `PMRB_IDX_CTL:
          begin
            if (wr_port)
              ctl_p2 <= wr_data & `PMRB_CTL_MASK_P2;
            else
              ctl_p1 <= wr_data & `PMRB_CTL_MASK_P1;
            restart_an_out[wr_port] <= wr_data[`PMRB_CTL_RSTAN];
          end
          `PMRB_IDX_ADV:
          begin
            if (wr_port)
              adv_p2 <= wr_data & `PMRB_ADV_MASK;
            else
              adv_p1 <= wr_data & `PMRB_ADV_MASK;
          end
          `PMRB_IDX_CDG:
          begin
            if (wr_port && wr_data[`PMRB_CDG_EN])
              cdg_run <= 1'b1;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Host readback, one cycle after the strobe
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
      host_rdata_out <= 16'h0000;
    else if (host_rd_in)
      host_rdata_out <= rd_word(host_port_in, phy_register_index_in);
  end

  // Pin synchronisers; first stages feed only second stages
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      mdc_s1   <= 1'b0;
      mdc_s2   <= 1'b0;
      mdc_prev <= 1'b0;
      mdio_s1  <= 1'b1;
      mdio_s2  <= 1'b1;
    end
    else
    begin
      mdc_s1   <= mdc_in;
      mdc_s2   <= mdc_s1;
      mdc_prev <= mdc_s2;
      mdio_s1  <= mdio_in;
      mdio_s2  <= mdio_s1;
    end
  end

  // Management frame engine, stepped on each detected MDC rise
  always @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      state         <= ST_IDLE;
      pre_cnt       <= 6'h00;
      bit_cnt       <= 4'h0;
      hdr           <= 12'h000;
      shreg         <= 16'h0000;
      hit           <= 1'b0;
      hit_port      <= 1'b0;
      mw_pend       <= 1'b0;
      mw_port       <= 1'b0;
      mw_idx        <= 5'h00;
      mw_data       <= 16'h0000;
      mdio_out      <= 1'b1;
      mdio_oe_n_out <= 1'b1;
    end
    else
    begin
      if (mw_pend && !host_wr_in)
        mw_pend <= 1'b0;
      if (mdc_rise)
      begin
        case (state)
          ST_IDLE:
          begin
            if (mdio_s2)
            begin
              if (pre_cnt != `PMRB_PRE_MIN)
                pre_cnt <= pre_cnt + 6'h01;
            end
            else
            begin
              pre_cnt <= 6'h00;
              if (pre_cnt == `PMRB_PRE_MIN)
                state <= ST_SOF;
            end
          end
          ST_SOF:
          begin
            bit_cnt <= 4'h0;
            state   <= mdio_s2 ? ST_HDR : ST_IDLE;
          end
          ST_HDR:
          begin
            hdr     <= {hdr[10:0], mdio_s2};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `PMRB_HDR_BITS - 4'h1)
            begin
              bit_cnt  <= 4'h0;
              state    <= ST_TA;
              // The last header bit is still on the line, so the address sits one bit lower
              hit      <= (hdr[8:4] == addr_p1) || (hdr[8:4] == addr_p2);
              hit_port <= (hdr[8:4] == addr_p2);
            end
          end
          ST_TA:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h0)
            begin
              hit <= (hdr[9:5] == addr_p1) || (hdr[9:5] == addr_p2);
              if (hdr[11:10] == `PMRB_OP_READ &&
                  ((hdr[9:5] == addr_p1) || (hdr[9:5] == addr_p2)))
              begin
                shreg         <= rd_word(hit_port, hdr[4:0]);
                mdio_out      <= 1'b0;
                mdio_oe_n_out <= 1'b0;
              end
            end
            else
            begin
              bit_cnt <= 4'h0;
              state   <= ST_DATA;
              if (!mdio_oe_n_out)
              begin
                mdio_out <= shreg[15];
                shreg    <= {shreg[14:0], 1'b0};
              end
            end
          end
          ST_DATA:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (!mdio_oe_n_out)
            begin
              mdio_out <= shreg[15];
              shreg    <= {shreg[14:0], 1'b0};
            end
            else
              shreg <= {shreg[14:0], mdio_s2};
            if (bit_cnt == `PMRB_DATA_LAST)
            begin
              state         <= ST_IDLE;
              pre_cnt       <= 6'h00;
              mdio_out      <= 1'b1;
              mdio_oe_n_out <= 1'b1;
              if (mdio_oe_n_out && hit && hdr[11:10] == `PMRB_OP_WRITE)
              begin
                mw_pend <= 1'b1;
                mw_port <= hit_port;
                mw_idx  <= hdr[4:0];
                mw_data <= {shreg[14:0], mdio_s2};
              end
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Port controls driven straight from the stored control words, advertisement words and diagnostic run flag
  assign far_loopback_out               = {ctl_p2[`PMRB_CTL_LOOP], ctl_p1[`PMRB_CTL_LOOP]};
  assign force_100_out                  = {ctl_p2[`PMRB_CTL_F100], ctl_p1[`PMRB_CTL_F100]};
  assign an_enable_out                  = {ctl_p2[`PMRB_CTL_ANEN], ctl_p1[`PMRB_CTL_ANEN]};
  assign power_down_out                 = {ctl_p2[`PMRB_CTL_PDN], ctl_p1[`PMRB_CTL_PDN]};
  assign full_duplex_out                = {ctl_p2[`PMRB_CTL_FDX], ctl_p1[`PMRB_CTL_FDX]};
  assign crossover_algorithm_select_out = {ctl_p2[`PMRB_CTL_XALG], ctl_p1[`PMRB_CTL_XALG]};
  assign force_mdi_out                  = {ctl_p2[`PMRB_CTL_FMDI], ctl_p1[`PMRB_CTL_FMDI]};
  assign disable_mdix_out               = {ctl_p2[`PMRB_CTL_DMDIX], ctl_p1[`PMRB_CTL_DMDIX]};
  assign disable_far_fault_out          = ctl_p1[`PMRB_CTL_DFEF];
  assign disable_tx_out                 = {ctl_p2[`PMRB_CTL_DTX], ctl_p1[`PMRB_CTL_DTX]};
  assign disable_led_out                = {ctl_p2[`PMRB_CTL_DLED], ctl_p1[`PMRB_CTL_DLED]};
  assign adv_ability_p1_out             = {adv_p1[`PMRB_ABL_PAUSE], adv_p1[`PMRB_ABL_HI:`PMRB_ABL_LO]};
  assign adv_ability_p2_out             = {adv_p2[`PMRB_ABL_PAUSE], adv_p2[`PMRB_ABL_HI:`PMRB_ABL_LO]};
  assign cable_diag_start_out           = cdg_run;

endmodule

/* File: pmrb_consts.vh */
/*
  Constants of the PHY management register bank: register indices, bit
  positions, masks, reset values and management frame codes.
  Assumes inclusion by the bank's design file only.
*/
`ifndef PMRB_CONSTS_VH
`define PMRB_CONSTS_VH

// Register indices
`define PMRB_IDX_CTL        5'h00
`define PMRB_IDX_STS        5'h01
`define PMRB_IDX_IDH        5'h02
`define PMRB_IDX_IDL        5'h03
`define PMRB_IDX_ADV        5'h04
`define PMRB_IDX_LPA        5'h05
`define PMRB_IDX_CDG        5'h1D
`define PMRB_IDX_SPC        5'h1F

// Default port addresses
`define PMRB_ADDR_P1        5'h01
`define PMRB_ADDR_P2        5'h02

// Global control field holding the programmed base address
`define PMRB_GC_ADDR_HI     7
`define PMRB_GC_ADDR_LO     3

// Basic control bits
`define PMRB_CTL_LOOP       14
`define PMRB_CTL_F100       13
`define PMRB_CTL_ANEN       12
`define PMRB_CTL_PDN        11
`define PMRB_CTL_RSTAN      9
`define PMRB_CTL_FDX        8
`define PMRB_CTL_XALG       5
`define PMRB_CTL_FMDI       4
`define PMRB_CTL_DMDIX      3
`define PMRB_CTL_DFEF       2
`define PMRB_CTL_DTX        1
`define PMRB_CTL_DLED       0
`define PMRB_CTL_MASK_P1    16'h793F
`define PMRB_CTL_MASK_P2    16'h793B
`define PMRB_CTL_RESET      16'h1020

// Basic status
`define PMRB_STS_ABIL       16'h7800
`define PMRB_STS_ANDONE     5
`define PMRB_STS_FEF        4
`define PMRB_STS_ANCAP      3
`define PMRB_STS_LINK       2

// Advertisement and partner ability
`define PMRB_ADV_MASK       16'h05E0
`define PMRB_ADV_RESET      16'h05E0
`define PMRB_ADV_SEL        16'h0001
`define PMRB_ABL_LO         5
`define PMRB_ABL_HI         8
`define PMRB_ABL_PAUSE      10

// Cable diagnostic
`define PMRB_CDG_EN         15
`define PMRB_CDG_RES_LO     13
`define PMRB_CDG_SHORT      12

// Special control/status
`define PMRB_SPC_POL        5

// Management frame
`define PMRB_OP_READ        2'h2
`define PMRB_OP_WRITE       2'h1
`define PMRB_HDR_BITS       4'hC
`define PMRB_DATA_LAST      4'hF
`define PMRB_PRE_MIN        6'h20

`endif

/* File: pmrb_mgmt_model.sv */
/*
  Station management controller model: runs whole MDIO frames.
  Assumes the bench resolves the line with a pull-up.
*/
`timescale 1ns/10ps
module pmrb_mgmt_model (
  output reg  mdc_out,
  output reg  drv_out,
  output reg  en_out,
  input  wire line_in
);
  initial
  begin
    mdc_out = 1'b0;
    drv_out = 1'b1;
    en_out  = 1'b0;
  end
  // MDC stands low between frames; data changes in the low half
  task automatic xfer(input [1:0] op, input [4:0] ad, input [4:0] ix,
                      input [15:0] wd, output [15:0] rd);
    reg [63:0] s;
    integer    i;
    begin
      s  = {32'hFFFFFFFF, 2'b01, op, ad, ix, 2'b10, wd};
      rd = 16'h0000;
      for (i = 63; i >= 0; i = i - 1)
      begin
        en_out  = !(op == 2'b10 && i < 18);
        drv_out = s[i];
        #80 mdc_out = 1'b1;
        if (i < 16)
          rd = {rd[14:0], line_in};
        #80 mdc_out = 1'b0;
      end
      en_out = 1'b0;
      #400;
    end
  endtask
endmodule

/* File: pmrb_bank_properties.sv */
/*
  Assertions on the host side of the PHY management bank.
  Assumes restart writes are never issued on consecutive cycles.
*/
`timescale 1ns/10ps
module pmrb_bank_properties #(
  parameter [15:0] ID_HIGH = 16'hA5A5 // Arbitrary identifier value
) (
  input wire        mclk_in,
  input wire        nrst_in,
  input wire        host_wr_in,
  input wire        host_rd_in,
  input wire        host_port_in,
  input wire [4:0]  phy_register_index_in,
  input wire [15:0] host_wdata_in,
  input wire [15:0] host_rdata_out,
  input wire [1:0]  an_done_in,
  input wire [1:0]  link_up_in,
  input wire [1:0]  far_end_fault_in,
  input wire [1:0]  far_loopback_out,
  input wire [1:0]  force_100_out,
  input wire [1:0]  an_enable_out,
  input wire [1:0]  power_down_out,
  input wire [1:0]  restart_an_out,
  input wire [1:0]  full_duplex_out,
  input wire [1:0]  crossover_algorithm_select_out,
  input wire        disable_far_fault_out,
  input wire [1:0]  disable_tx_out,
  input wire        cable_diag_start_out
);
  default clocking dck @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  wire [4:0] ix  = phy_register_index_in;
  wire       wr0 = host_wr_in && ix == 5'h00;
  // Port one has no cable diagnostic register
  wire       uns = ix > 5'h05 && ix != 5'h1F && !(ix == 5'h1D && host_port_in);

  AST_RESET:
    assert property ($rose(nrst_in) |-> an_enable_out == 2'b11 && crossover_algorithm_select_out == 2'b11
      && force_100_out == 2'b00 && power_down_out == 2'b00 && full_duplex_out == 2'b00)
    else $error("control outputs wrong after reset");
  AST_RESTART:
    assert property (wr0 && host_wdata_in[9] |=> restart_an_out == ($past(host_port_in) ? 2'b10 : 2'b01)
      ##1 restart_an_out == 2'b00)
    else $error("restart pulse wrong");
  AST_CTL_P1:
    assert property (wr0 && !host_port_in |=> {far_loopback_out[0], force_100_out[0], an_enable_out[0],
      power_down_out[0], full_duplex_out[0]} == $past({host_wdata_in[14:11], host_wdata_in[8]}))
    else $error("port one control outputs wrong");
  AST_FEF:
    assert property (wr0 |=> disable_far_fault_out ==
      ($past(host_port_in) ? $past(disable_far_fault_out) : $past(host_wdata_in[2])))
    else $error("far fault disable wrong");
  AST_STATUS:
    assert property (host_rd_in && ix == 5'h01 |=> host_rdata_out == {5'h0F, 5'h00,
      $past(an_done_in[host_port_in]), $past(far_end_fault_in[host_port_in]),
      $past(an_enable_out[host_port_in]), $past(link_up_in[host_port_in]), 2'b00})
    else $error("status word wrong");
  AST_ID:
    assert property (host_rd_in && ix == 5'h02 |=> host_rdata_out == ID_HIGH)
    else $error("identifier wrong");
  AST_UNS_WR:
    assert property (host_wr_in && uns |=> $stable({far_loopback_out, an_enable_out, power_down_out,
      disable_tx_out, cable_diag_start_out}))
    else $error("unsupported write had an effect");
  AST_UNS_RD:
    assert property (host_rd_in && ix > 5'h05 && ix < 5'h1D |=> host_rdata_out == 16'h0000)
    else $error("unsupported read not zero");

  cover property (host_rd_in && ix == 5'h01 && link_up_in != 2'b00);
  cover property (wr0 && host_wdata_in[9]);
  cover property (host_wr_in && uns);
endmodule

bind pmrb_bank pmrb_bank_properties #(.ID_HIGH(ID_HIGH)) u_props (
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .host_wr_in(host_wr_in),
  .host_rd_in(host_rd_in),
  .host_port_in(host_port_in),
  .phy_register_index_in(phy_register_index_in),
  .host_wdata_in(host_wdata_in),
  .host_rdata_out(host_rdata_out),
  .an_done_in(an_done_in),
  .link_up_in(link_up_in),
  .far_end_fault_in(far_end_fault_in),
  .far_loopback_out(far_loopback_out),
  .force_100_out(force_100_out),
  .an_enable_out(an_enable_out),
  .power_down_out(power_down_out),
  .restart_an_out(restart_an_out),
  .full_duplex_out(full_duplex_out),
  .crossover_algorithm_select_out(crossover_algorithm_select_out),
  .disable_far_fault_out(disable_far_fault_out),
  .disable_tx_out(disable_tx_out),
  .cable_diag_start_out(cable_diag_start_out)
);

/* File: pmrb_bank_tb.sv */
/*
  Self-checking bench for the PHY management bank: host accesses and MDIO frames.
  Assumes the MDIO line has a pull-up, so an unanswered read gives all ones.
*/
`timescale 1ns/10ps
module pmrb_bank_tb;
  reg         mclk = 1'b0;
  reg         nrst = 1'b0;
  reg         hwr = 1'b0;
  reg         hrd = 1'b0;
  reg         hport = 1'b0;
  reg  [4:0]  hix = 5'h00;
  reg  [15:0] hwd = 16'h0000;
  reg         gwr = 1'b0;
  reg  [7:0]  gd = 8'h00;
  reg  [1:0]  an_done = 2'b00;
  reg  [1:0]  link = 2'b00;
  reg  [1:0]  fef = 2'b00;
  reg  [1:0]  pol = 2'b00;
  reg  [4:0]  lp1 = 5'h15;
  reg         cdone = 1'b0;
  wire [1:0]  f100;
  wire [1:0]  anen;
  wire [1:0]  fdx;
  wire [1:0]  xalg;
  wire [1:0]  fmdi;
  wire [1:0]  dmdix;
  wire [1:0]  dtx;
  wire [1:0]  dled;
  wire [4:0]  adv1;
  wire [4:0]  adv2;
  reg  [15:0] r;
  wire [15:0] hrdata;
  wire [1:0]  loop;
  wire [1:0]  pdn;
  wire        dfef;
  wire        cds;
  wire        mo;
  wire        moe_n;
  wire        mdc;
  wire        mdrv;
  wire        men;
  wire        line = !moe_n ? mo : (men ? mdrv : 1'b1);
  integer     err_count = 0;
  integer     checks_done = 0;

  pmrb_bank #(.ID_HIGH(16'h1357)) u_dut (
    .mclk_in(mclk), .nrst_in(nrst), .mdc_in(mdc), .mdio_in(line), .mdio_out(mo), .mdio_oe_n_out(moe_n),
    .gc13_wr_in(gwr), .gc13_data_in(gd), .host_wr_in(hwr), .host_rd_in(hrd), .host_port_in(hport),
    .phy_register_index_in(hix), .host_wdata_in(hwd), .host_rdata_out(hrdata), .an_done_in(an_done),
    .link_up_in(link), .far_end_fault_in(fef), .lp_ability_p1_in(lp1), .lp_ability_p2_in(5'h0A),
    .polarity_rev_in(pol), .cable_diag_done_in(cdone), .cable_diag_result_in(2'b01),
    .cable_diag_short_in(1'b0), .cable_diag_count_in(9'h012), .far_loopback_out(loop),
    .force_100_out(f100), .an_enable_out(anen), .power_down_out(pdn), .restart_an_out(), .full_duplex_out(fdx),
    .crossover_algorithm_select_out(xalg), .force_mdi_out(fmdi), .disable_mdix_out(dmdix),
    .disable_far_fault_out(dfef), .disable_tx_out(dtx), .disable_led_out(dled), .adv_ability_p1_out(adv1),
    .adv_ability_p2_out(adv2), .cable_diag_start_out(cds)
  );
  pmrb_mgmt_model u_mdm (.mdc_out(mdc), .drv_out(mdrv), .en_out(men), .line_in(line));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task hw(input p, input [4:0] i, input [15:0] d);
    begin
      @(posedge mclk) #1;
      hwr = 1'b1;
      hport = p;
      hix = i;
      hwd = d;
      @(posedge mclk) #1;
      hwr = 1'b0;
    end
  endtask
  task hr(input p, input [4:0] i, output [15:0] d);
    begin
      @(posedge mclk) #1;
      hrd = 1'b1;
      hport = p;
      hix = i;
      @(posedge mclk) #1;
      hrd = 1'b0;
      d = hrdata;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial
  begin
    #500000;
    err_count = err_count + 1;
    complete_run;
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    hr(0, 5'h00, r);
    chk("ctl1 reset", 16'h1020, r);
    hr(0, 5'h01, r);
    chk("sts1 reset", 16'h7808, r);
    chk("adv outs", 16'h03FF, {6'h00, adv1, adv2});
    hr(1, 5'h04, r);
    chk("adv2 rd", 16'h05E1, r);
    $display("test reset done");
    link = 2'b10;
    an_done = 2'b10;
    u_mdm.xfer(2'b10, 5'h02, 5'h01, 16'h0000, r);
    chk("mdio sts2", 16'h782C, r);
    u_mdm.xfer(2'b10, 5'h01, 5'h00, 16'h0000, r);
    chk("mdio ctl1", 16'h1020, r);
    u_mdm.xfer(2'b01, 5'h02, 5'h00, 16'h4000, r);
    hr(1, 5'h00, r);
    chk("ctl2 host", 16'h4000, r);
    chk("loopback", 16'h0002, {14'h0, loop});
    $display("test mdio done");
    hw(0, 5'h00, 16'hFFFF);
    hw(1, 5'h00, 16'hFFFF);
    hr(0, 5'h00, r);
    chk("ctl1 all", 16'h793F, r);
    hr(1, 5'h00, r);
    chk("ctl2 all", 16'h793B, r);
    chk("fef off", 16'h0001, {15'h0, dfef});
    chk("pdn", 16'h0003, {14'h0, pdn});
    chk("ctl outs", 16'hFFFF, {fmdi, dmdix, dtx, dled, xalg, f100, anen, fdx});
    fef = 2'b01;
    hw(0, 5'h00, 16'h0000);
    hw(1, 5'h01, 16'h0000);
    hr(0, 5'h01, r);
    chk("sts1 fef", 16'h7810, r);
    hr(1, 5'h01, r);
    chk("sts2", 16'h782C, r);
    chk("ctl outs p1", 16'hAAAA, {fmdi, dmdix, dtx, dled, xalg, f100, anen, fdx});
    $display("test control done");
    hw(0, 5'h1D, 16'h8000);
    chk("diag p1", 16'h0000, {15'h0, cds});
    hw(1, 5'h1D, 16'h8000);
    chk("diag p2", 16'h0001, {15'h0, cds});
    cdone = 1'b1;
    @(posedge mclk) #1;
    cdone = 1'b0;
    chk("diag done", 16'h0000, {15'h0, cds});
    hr(1, 5'h1D, r);
    chk("diag rd", 16'h2012, r);
    hw(1, 5'h10, 16'h0000);
    hr(1, 5'h00, r);
    chk("ctl2 kept", 16'h793B, r);
    hr(0, 5'h06, r);
    chk("unsup rd", 16'h0000, r);
    hr(0, 5'h02, r);
    chk("id high", 16'h1357, r);
    hr(0, 5'h05, r);
    chk("lp abil", 16'h04A0, r);
    hw(0, 5'h04, 16'h0100);
    chk("adv outs wr", 16'h011F, {6'h00, adv1, adv2});
    pol = 2'b10;
    hr(1, 5'h1F, r);
    chk("special", 16'h0020, r);
    $display("test index map done");
    gwr = 1'b1;
    gd = 8'h28;
    @(posedge mclk) #1;
    gwr = 1'b0;
    u_mdm.xfer(2'b10, 5'h05, 5'h00, 16'h0000, r);
    chk("addr5 ctl", 16'h0000, r);
    u_mdm.xfer(2'b10, 5'h06, 5'h00, 16'h0000, r);
    chk("addr6 ctl", 16'h793B, r);
    u_mdm.xfer(2'b10, 5'h01, 5'h00, 16'h0000, r);
    chk("old addr", 16'hFFFF, r);
    $display("test address done");
    complete_run;
  end
endmodule
